/* dv/cct_pin_src.sv */
// Signal source model that drives the capture pins of every channel.
`timescale 1ns/100ps
module cct_pin_src (
  input wire logic mclk,
  input wire logic alt_pin_map_sel,
  output logic [2:0] ded_pin_in,
  output logic [3:0] pe_pin_in,
  output logic [3:0] ph_pin_in
);
  logic [6:0] lvl = 7'h00;
  logic [2:0] tc = 3'h0;
  always @(posedge mclk) tc <= tc + 3'h1;
  assign ded_pin_in = {lvl[6], lvl[1], lvl[0]};
  // The port that is not routed keeps moving, so a wrong routing shows up as stray captures.
  assign pe_pin_in = alt_pin_map_sel ? {lvl[2], lvl[3], lvl[4], lvl[5]} : {4{tc[2]}};
  assign ph_pin_in = alt_pin_map_sel ? {4{tc[2]}} : {lvl[2], lvl[3], lvl[4], lvl[5]};
  // Each level stands eight clocks, so its capture lands before the next edge.
  task automatic pulses(input int ch, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge mclk);
      lvl[ch] <= ~lvl[ch];
      repeat (7) @(posedge mclk);
    end
    repeat (2) @(posedge mclk);
  endtask : pulses
endmodule : cct_pin_src

/* dv/cct_top_bench.sv */
// Self-checking bench of the capture channel timer-select block.
`timescale 1ns/100ps
module cct_top_bench;
  import cct_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  cct_bus_req_type bus_req = '0;
  logic [DW-1:0] bus_rdata;
  logic [3:0][TW-1:0] cc_timer_val = {16'h789a, 16'h5678, 16'h3456, 16'h1234};
  logic alt_sel = 1'b1;
  logic [NUM_CH-1:0] pin_direction = 7'h7f, port_latch = 7'h00, chan_out_val = 7'h00;
  logic [2:0] ded_in, ded_out, ded_oe_n;
  logic [3:0] pe_in, pe_out, pe_oe_n, ph_in, ph_out, ph_oe_n;
  cct_tsel_type [NUM_CH-1:0] chan_timer_sel;
  logic [NUM_CH-1:0] cap_ev, cap_flag, cap_ien;
  int err_total = 0, compares = 0, cycles = 0, ev_cnt = 0, ev_ch = 0;
  cct_top i_dut (.mclk(mclk), .arst_n(arst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .cc_timer_val(cc_timer_val), .alt_pin_map_sel(alt_sel), .pin_direction(pin_direction),
    .port_latch(port_latch), .chan_out_val(chan_out_val), .ded_pin_in(ded_in), .ded_pin_out(ded_out),
    .ded_pin_oe_n(ded_oe_n), .pe_pin_in(pe_in), .pe_pin_out(pe_out), .pe_pin_oe_n(pe_oe_n),
    .ph_pin_in(ph_in), .ph_pin_out(ph_out), .ph_pin_oe_n(ph_oe_n), .chan_timer_sel(chan_timer_sel),
    .capture_event(cap_ev), .capture_flag(cap_flag), .capture_irq_enable(cap_ien));
  cct_pin_src src (.mclk(mclk), .alt_pin_map_sel(alt_sel), .ded_pin_in(ded_in), .pe_pin_in(pe_in),
    .ph_pin_in(ph_in));
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cap_ev[ev_ch] === 1'b1) ev_cnt <= ev_cnt + 1;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask : wr
  task automatic rchk(input string what, input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    @(negedge mclk);
    chk(what, bus_rdata, exp);
  endtask : rchk
  task automatic pin_chk(input string what, input logic v, input logic [1:0] exp);
    @(posedge mclk);
    chan_out_val[0] <= v;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk(what, {ded_oe_n[0], ded_out[0]}, exp);
  endtask : pin_chk
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk("tsel_a", ADDR_TSEL_A, 8'h00);
    rchk("flags", ADDR_FLAG, 8'h00);
    rchk("unmapped", 8'h30, 8'h00);
    chk("sel_rst", chan_timer_sel, {7{8'h12}});
    wr(ADDR_IEN, 8'hff);
    rchk("ien", ADDR_IEN, 8'hfe);
    chk("ien_out", cap_ien, 7'h7f);
    $display("reset test done");
  endtask : t_reset
  task automatic t_tsel();
    // Code 11 appears only in the channel seven field, which defines it.
    logic [7:0] va [3] = '{8'h7d, 8'hc2, 8'h80};
    logic [7:0] ra [3] = '{8'h55, 8'hc2, 8'h80};
    logic [31:0] ea [3] = '{32'h54525434, 32'h58121236, 32'h56121212};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_TSEL_A, va[i]);
      rchk("tsel_a", ADDR_TSEL_A, ra[i]);
      chk("sel_a", chan_timer_sel[3:0], ea[i]);
    end
    wr(ADDR_TSEL_B, 8'hfd);
    rchk("tsel_b", ADDR_TSEL_B, 8'h15);
    chk("sel_b", chan_timer_sel[6:4], 24'h727474);
    wr(ADDR_TSEL_B, 8'h02);
    rchk("tsel_b", ADDR_TSEL_B, 8'h02);
    chk("sel_b", chan_timer_sel[6:4], 24'h121276);
    $display("timer select test done");
  endtask : t_tsel
  task automatic t_capture();
    wr(ADDR_TSEL_A, 8'h01);
    wr(8'h00, {4'h0, MODE_RISE});
    wr(ADDR_FLAG, 8'h00);
    for (int k = 0; k < 2; k++) begin
      ev_cnt = 0;
      src.pulses(0, 1);
      chk("events", ev_cnt, 1);
      rchk("cap_lo", 8'h01, cc_timer_val[1][7:0]);
      rchk("cap_hi", 8'h02, cc_timer_val[1][15:8]);
      chk("flag", cap_flag[0], 1'b1);
      @(posedge mclk);
      cc_timer_val[1] <= 16'hbeef;
    end
    wr(8'h01, 8'h5a);
    rchk("lo_rw", 8'h01, 8'h5a);
    wr(ADDR_FLAG, 8'h00);
    rchk("flag_clr", ADDR_FLAG, 8'h00);
    $display("capture test done");
  endtask : t_capture
  task automatic t_presc();
    logic [3:0] md [5] = '{MODE_FALL, MODE_RISE, MODE_RISE4, MODE_RISE16, MODE_OFF};
    int np [5] = '{3, 3, 8, 16, 3};
    int ne [5] = '{3, 3, 2, 1, 0};
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, 8'h00);
      wr(8'h00, {4'h0, md[i]});
      ev_cnt = 0;
      src.pulses(0, np[i]);
      chk("presc_events", ev_cnt, ne[i]);
    end
    $display("prescaler test done");
  endtask : t_presc
  task automatic t_pins();
    wr(8'h00, {4'h0, MODE_RISE});
    pin_direction <= 7'h7e;
    ev_cnt = 0;
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      port_latch[0] <= ~port_latch[0];
      repeat (7) @(posedge mclk);
    end
    chk("port_cap", ev_cnt, 1);
    wr(8'h00, 8'h08);
    wr(ADDR_OPEN_DRAIN, 8'h04);
    pin_chk("od_hi", 1'b1, 2'b10);
    pin_chk("od_lo", 1'b0, 2'b00);
    wr(ADDR_OPEN_DRAIN, 8'h00);
    pin_chk("pp_hi", 1'b1, 2'b01);
    @(posedge mclk);
    pin_direction <= 7'h7f;
    alt_sel <= 1'b0;
    repeat (5) @(posedge mclk);
    chk("port_idle", {pe_out, pe_oe_n, ph_out, ph_oe_n}, 16'h0f0f);
    wr(8'h08, {4'h0, MODE_RISE});
    ev_ch = 2;
    ev_cnt = 0;
    src.pulses(2, 2);
    chk("alt_cap", ev_cnt, 2);
    $display("pin test done");
  endtask : t_pins
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_tsel();
    t_capture();
    t_presc();
    t_pins();
    report_and_stop();
  end
endmodule : cct_top_bench

/* hw/cct_cap_chan.sv */
// One capture channel: pin synchroniser, edge detect, prescaler and capture register.
`timescale 1ns/100ps
module cct_cap_chan #(
  parameter int TW_P = cct_pkg::TW
) (
  input logic mclk,
  input logic arst_n,
  input logic [cct_pkg::MODE_W-1:0] mode,
  input logic pin_raw,
  input logic pin_is_out,
  input logic port_latch,
  input logic [TW_P-1:0] timer_val,
  input logic wr_lo,
  input logic wr_hi,
  input logic [cct_pkg::DW-1:0] wdata,
  output logic [TW_P-1:0] cap_value,
  output logic cap_pulse
);
  import cct_pkg::*;

  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic prev;
    logic [MODE_W-1:0] count;
    logic hit;
    logic pulse;
    logic [TW_P-1:0] cap;
  } cct_chan_state_type;

  cct_chan_state_type st_q;
  cct_chan_state_type st_d;
  logic obs;
  logic rise;
  logic fall;

  always_comb begin
    st_d = st_q;
    obs = pin_is_out ? port_latch : st_q.level;
    rise = obs && !st_q.prev;
    fall = !obs && st_q.prev;
    st_d.sync = {st_q.sync[1:0], pin_raw};
    // The level moves only once the last two stages agree, which rejects a metastable settle.
    if (st_q.sync[1] == st_q.sync[2]) begin
      st_d.level = st_q.sync[2];
    end
    st_d.prev = obs;
    st_d.pulse = st_q.hit;
    st_d.hit = 1'b0;
    if (!cct_is_capture(mode)) begin
      st_d.count = '0;
    end else begin
      // Switching prescale keeps the count, so the first capture may come early.
      if (rise) begin
        st_d.count = st_q.count + 4'h1;
      end
      unique case (mode)
        MODE_FALL: st_d.hit = fall;
        MODE_RISE: st_d.hit = rise;
        MODE_RISE4: st_d.hit = rise && ((st_q.count & PRESC4_MASK) == PRESC4_MASK);
        MODE_RISE16: st_d.hit = rise && ((st_q.count & PRESC16_MASK) == PRESC16_MASK);
        default: st_d.hit = 1'b0;
      endcase
    end
    if (wr_lo) begin
      st_d.cap[DW-1:0] = wdata;
    end
    if (wr_hi) begin
      st_d.cap[2*DW-1:DW] = wdata;
    end
    if (st_q.hit) begin
      st_d.cap = timer_val;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cap_value = st_q.cap;
  assign cap_pulse = st_q.pulse;

  snap_value_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q.hit |=> (cap_value == $past(timer_val)) && cap_pulse)
    else $error("capture did not take the timer snapshot");
  presc_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !cct_is_capture(mode) |=> (st_q.count == '0) && !st_q.hit)
    else $error("prescaler not cleared outside capture");
  presc_sixteen_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_q.hit && ($past(mode) == MODE_RISE16)) |-> ($past(st_q.count) == PRESC16_MASK))
    else $error("sixteenth edge capture at wrong count");
  fall_edge_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_q.hit && ($past(mode) == MODE_FALL)) |-> ($past(st_q.prev) && !$past(obs)))
    else $error("falling capture without a falling edge");
endmodule : cct_cap_chan

/* hw/cct_pin_drv.sv */
// Registered pin driver of one channel with the open-drain option.
`timescale 1ns/100ps
module cct_pin_drv (
  input logic mclk,
  input logic arst_n,
  input logic [cct_pkg::MODE_W-1:0] mode,
  input logic od_en,
  input logic dir_in,
  input logic val,
  output cct_pkg::cct_pin_drv_type drv
);
  import cct_pkg::*;

  typedef struct packed {
    cct_pin_drv_type drv;
  } cct_drv_state_type;

  cct_drv_state_type st_q;
  cct_drv_state_type st_d;
  logic drive;

  always_comb begin
    st_d = st_q;
    drive = cct_is_output(mode) && !dir_in;
    st_d.drv.out = val && !od_en;
    // An open-drain pin only ever pulls low; a high level is left to the pull-up.
    st_d.drv.oe_n = !(drive && (!od_en || !val));
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '{drv: PIN_IDLE};
    end else begin
      st_q <= st_d;
    end
  end

  assign drv = st_q.drv;

  od_release_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (od_en && val) |=> drv.oe_n)
    else $error("open-drain pin driven high");
endmodule : cct_pin_drv

/* hw/cct_pkg.sv */
// Shared constants, carrier types and helpers of the capture channel timer-select block.
package cct_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 7;
  localparam int DW = 8;
  localparam int AW = 8;
  localparam int TW = 16;
  localparam int MODE_W = 4;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] CH_STRIDE = 8'h04;
  localparam logic [AW-1:0] CH_REGION_END = 8'h1c;
  localparam logic [1:0] CH_CTRL = 2'h0;
  localparam logic [1:0] CH_LO = 2'h1;
  localparam logic [1:0] CH_HI = 2'h2;
  localparam logic [AW-1:0] ADDR_TSEL_A = 8'h20;
  localparam logic [AW-1:0] ADDR_TSEL_B = 8'h21;
  localparam logic [AW-1:0] ADDR_OPEN_DRAIN = 8'h22;
  localparam logic [AW-1:0] ADDR_FLAG = 8'h23;
  localparam logic [AW-1:0] ADDR_IEN = 8'h24;
  localparam logic [DW-1:0] RESET_VAL = 8'h00;
  localparam logic [DW-1:0] CTRL_MASK = 8'h3f;
  localparam logic [DW-1:0] TSA_MASK = 8'hd7;
  localparam logic [DW-1:0] TSB_MASK = 8'h17;
  localparam logic [DW-1:0] TSB_MASK_SMALL = 8'h03;
  localparam logic [DW-1:0] OD_MASK = 8'hfc;
  localparam logic [DW-1:0] FLAG_MASK = 8'hfe;
  localparam logic [DW-1:0] FLAG_MASK_SMALL = 8'h3e;
  localparam int OD_LSB = 2;
  localparam int OD_CHANNELS = 6;
  localparam int FLAG_LSB = 1;
  // ----------------------------------------------------------------
  // Timer-select field positions and channel indexes
  // ----------------------------------------------------------------
  localparam int SEL4_LSB = 0;
  localparam int SEL5_BIT = 2;
  localparam int SEL6_BIT = 4;
  localparam int SEL7_LSB = 6;
  localparam int SEL8_LSB = 0;
  localparam int SEL9_BIT = 2;
  localparam int SEL10_BIT = 4;
  localparam int CH_IDX_FOUR = 0;
  localparam int CH_IDX_FIVE = 1;
  localparam int CH_IDX_SIX = 2;
  localparam int CH_IDX_SEVEN = 3;
  localparam int CH_IDX_EIGHT = 4;
  localparam int CH_IDX_NINE = 5;
  localparam int CH_IDX_TEN = 6;
  // ----------------------------------------------------------------
  // Mode codes and prescaler
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_OFF = 4'h0;
  localparam logic [MODE_W-1:0] MODE_TOGGLE = 4'h2;
  localparam logic [MODE_W-1:0] MODE_FALL = 4'h4;
  localparam logic [MODE_W-1:0] MODE_RISE = 4'h5;
  localparam logic [MODE_W-1:0] MODE_RISE4 = 4'h6;
  localparam logic [MODE_W-1:0] MODE_RISE16 = 4'h7;
  localparam logic [MODE_W-1:0] PRESC4_MASK = 4'h3;
  localparam logic [MODE_W-1:0] PRESC16_MASK = 4'hf;
  localparam logic [MODE_W-1:0] CAP_CLASS_MASK = 4'hc;
  localparam logic [MODE_W-1:0] OUT_CLASS_MASK = 4'h8;
  // ----------------------------------------------------------------
  // Timer numbers
  // ----------------------------------------------------------------
  localparam logic [3:0] TMR_ONE = 4'h1;
  localparam logic [3:0] TMR_TWO = 4'h2;
  localparam logic [3:0] TMR_THREE = 4'h3;
  localparam logic [3:0] TMR_FOUR = 4'h4;
  localparam logic [3:0] TMR_FIVE = 4'h5;
  localparam logic [3:0] TMR_SIX = 4'h6;
  localparam logic [3:0] TMR_SEVEN = 4'h7;
  localparam logic [3:0] TMR_EIGHT = 4'h8;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } cct_bus_req_type;
  typedef struct packed {
    logic [3:0] cc;
    logic [3:0] pwm;
  } cct_tsel_type;
  typedef struct packed {
    logic out;
    logic oe_n;
  } cct_pin_drv_type;
  localparam cct_tsel_type TSEL_RESET = '{cc: TMR_ONE, pwm: TMR_TWO};
  localparam cct_pin_drv_type PIN_IDLE = '{out: 1'b0, oe_n: 1'b1};

  function automatic logic cct_is_capture(input logic [MODE_W-1:0] mode);
    return (mode & CAP_CLASS_MASK) == MODE_FALL;
  endfunction : cct_is_capture

  function automatic logic cct_is_output(input logic [MODE_W-1:0] mode);
    return (mode == MODE_TOGGLE) || ((mode & OUT_CLASS_MASK) == OUT_CLASS_MASK);
  endfunction : cct_is_output
endpackage : cct_pkg

/* hw/cct_top.sv */
// Capture channels with timer selection, open-drain drivers, pin mapping and register file.
// ----------------------------------------------------------------
// What this block does
// - Capture uses odd timers, PWM uses even.
// - All channels run together, sharing timers.
// - Select A covers channels four-seven, B eight-ten.
// - Decode channel four and five timer codes.
// - Decode channel six and seven timer codes.
// - Decode channels eight, nine, ten, full variant.
// - Small variant drops nine, ten; eight uses one.
// - Open-drain bit makes output driver open-drain.
// - Config bit maps channels six-nine to E/H.
// - Capture event copies sixteen-bit timer count.
// - Event is fall, rise, fourth or sixteenth.
// - Capture sets flag; only software clears it.
// - New capture overwrites the unread old value.
// - Port write on output pin triggers capture.
// - Prescaler cleared when off or not capturing.
// - Prescale change keeps count; may capture early.
// - Codes four to seven choose capture edge.
// - Mode zero disables channel and resets state.
// - Capture value is two byte registers, read/write.
// ----------------------------------------------------------------
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/100ps
module cct_top #(
  parameter bit SMALL_MEM = 1'b0
) (
  input logic mclk,
  input logic arst_n,
  input cct_pkg::cct_bus_req_type bus_req,
  output logic [cct_pkg::DW-1:0] bus_rdata,

  input logic [3:0][cct_pkg::TW-1:0] cc_timer_val,
  input logic alt_pin_map_sel,
  input logic [cct_pkg::NUM_CH-1:0] pin_direction,
  input logic [cct_pkg::NUM_CH-1:0] port_latch,
  input logic [cct_pkg::NUM_CH-1:0] chan_out_val,

  input logic [2:0] ded_pin_in,
  output logic [2:0] ded_pin_out,
  output logic [2:0] ded_pin_oe_n,
  input logic [3:0] pe_pin_in,
  output logic [3:0] pe_pin_out,
  output logic [3:0] pe_pin_oe_n,
  input logic [3:0] ph_pin_in,
  output logic [3:0] ph_pin_out,
  output logic [3:0] ph_pin_oe_n,

  output cct_pkg::cct_tsel_type [cct_pkg::NUM_CH-1:0] chan_timer_sel,
  output logic [cct_pkg::NUM_CH-1:0] capture_event,
  output logic [cct_pkg::NUM_CH-1:0] capture_flag,
  output logic [cct_pkg::NUM_CH-1:0] capture_irq_enable
);
  import cct_pkg::*;

  // ----------------------------------------------------------------
  // Timer-select decode
  // ----------------------------------------------------------------
  // Reserved codes fall back to timer one/two so a bad write cannot leave a channel without a time base.
  function automatic cct_tsel_type tsel_decode(input int k, input logic [DW-1:0] tsa, input logic [DW-1:0] tsb);
    cct_tsel_type t;
    t = TSEL_RESET;

    unique case (k)
      CH_IDX_FOUR: begin
        unique case (tsa[SEL4_LSB +: 2])
          2'b01: t = '{cc: TMR_THREE, pwm: TMR_FOUR};
          2'b10: t = '{cc: TMR_THREE, pwm: TMR_SIX};
          default: t = TSEL_RESET;
        endcase
      end
      CH_IDX_FIVE: if (tsa[SEL5_BIT]) t = '{cc: TMR_FIVE, pwm: TMR_FOUR};
      CH_IDX_SIX: if (tsa[SEL6_BIT]) t = '{cc: TMR_FIVE, pwm: TMR_TWO};
      CH_IDX_SEVEN: begin
        unique case (tsa[SEL7_LSB +: 2])
          2'b01: t = '{cc: TMR_FIVE, pwm: TMR_FOUR};
          2'b10: t = '{cc: TMR_FIVE, pwm: TMR_SIX};
          2'b11: t = '{cc: TMR_FIVE, pwm: TMR_EIGHT};
          default: t = TSEL_RESET;
        endcase
      end
      CH_IDX_EIGHT: begin
        unique case (tsb[SEL8_LSB +: 2])
          2'b01: t = '{cc: TMR_SEVEN, pwm: TMR_FOUR};
          2'b10: t = '{cc: TMR_SEVEN, pwm: TMR_SIX};
          default: t = TSEL_RESET;
        endcase
        if (SMALL_MEM) begin
          t.cc = TMR_ONE;
        end
      end
      CH_IDX_NINE: if (tsb[SEL9_BIT] && !SMALL_MEM) t = '{cc: TMR_SEVEN, pwm: TMR_FOUR};
      CH_IDX_TEN: if (tsb[SEL10_BIT] && !SMALL_MEM) t = '{cc: TMR_SEVEN, pwm: TMR_TWO};
      default: t = TSEL_RESET;
    endcase

    return t;
  endfunction : tsel_decode

  function automatic logic ch_present(input int k);
    return !(SMALL_MEM && (k >= CH_IDX_NINE));
  endfunction : ch_present

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DW-1:0] tsa;
    logic [DW-1:0] tsb;
    logic [DW-1:0] od;
    logic [DW-1:0] flag;
    logic [DW-1:0] ien;
    logic [NUM_CH-1:0][DW-1:0] ctrl;
    cct_tsel_type [NUM_CH-1:0] tsel;
    logic [DW-1:0] rdata;
  } cct_top_state_type;

  localparam cct_top_state_type RESET_STATE = '{
    tsa: RESET_VAL,
    tsb: RESET_VAL,
    od: RESET_VAL,
    flag: RESET_VAL,
    ien: RESET_VAL,
    ctrl: {NUM_CH{RESET_VAL}},
    tsel: {NUM_CH{TSEL_RESET}},
    rdata: RESET_VAL
  };

  localparam logic [DW-1:0] TSB_WMASK = SMALL_MEM ? TSB_MASK_SMALL : TSB_MASK;
  localparam logic [DW-1:0] FLAG_WMASK = SMALL_MEM ? FLAG_MASK_SMALL : FLAG_MASK;

  cct_top_state_type st_q;
  cct_top_state_type st_d;

  logic [NUM_CH-1:0][TW-1:0] cap_value;
  logic [NUM_CH-1:0][TW-1:0] chan_timer;
  logic [NUM_CH-1:0] cap_pulse;
  logic [NUM_CH-1:0] wr_lo;
  logic [NUM_CH-1:0] wr_hi;
  logic [NUM_CH-1:0] pin_raw;
  logic [NUM_CH-1:0] od_en;
  cct_pin_drv_type [NUM_CH-1:0] drv;

  logic in_region;
  int ch_idx;
  logic [1:0] reg_sel;
  logic [DW-1:0] rd_val;
  logic [DW-1:0] pulse_bits;

  // ----------------------------------------------------------------
  // Register file and flags
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    in_region = bus_req.addr < CH_REGION_END;
    ch_idx = int'(bus_req.addr / CH_STRIDE);
    reg_sel = 2'(bus_req.addr % CH_STRIDE);
    wr_lo = '0;
    wr_hi = '0;
    rd_val = RESET_VAL;
    pulse_bits = RESET_VAL;
    pulse_bits[FLAG_LSB +: NUM_CH] = cap_pulse;

    // The select decode is registered, so a new time base applies one clock after its write.
    for (int k = 0; k < NUM_CH; k++) begin
      st_d.tsel[k] = tsel_decode(k, st_q.tsa, st_q.tsb);
      if (bus_req.wr && in_region && (ch_idx == k) && ch_present(k)) begin
        if (reg_sel == CH_CTRL) begin
          st_d.ctrl[k] = bus_req.wdata & CTRL_MASK;
        end
        wr_lo[k] = reg_sel == CH_LO;
        wr_hi[k] = reg_sel == CH_HI;
      end
    end
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        ADDR_TSEL_A: st_d.tsa = bus_req.wdata & TSA_MASK;
        ADDR_TSEL_B: st_d.tsb = bus_req.wdata & TSB_WMASK;
        ADDR_OPEN_DRAIN: st_d.od = bus_req.wdata & OD_MASK;
        ADDR_FLAG: st_d.flag = bus_req.wdata & FLAG_WMASK;
        ADDR_IEN: st_d.ien = bus_req.wdata & FLAG_WMASK;
        default: st_d.tsa = st_q.tsa;
      endcase
    end

    // A capture in the same cycle as a software clear still leaves the flag set.
    st_d.flag = st_d.flag | pulse_bits;

    // Addresses that map to nothing, or to an absent channel, read zero and drop writes.
    if (bus_req.rd) begin
      if (in_region && ch_present(ch_idx)) begin
        unique case (reg_sel)
          CH_CTRL: rd_val = st_q.ctrl[ch_idx];
          CH_LO: rd_val = cap_value[ch_idx][DW-1:0];
          CH_HI: rd_val = cap_value[ch_idx][2*DW-1:DW];
          default: rd_val = RESET_VAL;
        endcase
      end else begin
        unique case (bus_req.addr)
          ADDR_TSEL_A: rd_val = st_q.tsa;
          ADDR_TSEL_B: rd_val = st_q.tsb;
          ADDR_OPEN_DRAIN: rd_val = st_q.od;
          ADDR_FLAG: rd_val = st_q.flag;
          ADDR_IEN: rd_val = st_q.ien;
          default: rd_val = RESET_VAL;
        endcase
      end
    end

    // Read data stand for one clock after the strobe and are zero otherwise.
    st_d.rdata = rd_val;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= RESET_STATE;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin mapping
  // ----------------------------------------------------------------
  always_comb begin
    pin_raw = '0;
    od_en = '0;
    ded_pin_out = '0;
    ded_pin_oe_n = '1;
    pe_pin_out = '0;
    pe_pin_oe_n = '1;
    ph_pin_out = '0;
    ph_pin_oe_n = '1;

    pin_raw[CH_IDX_FOUR] = ded_pin_in[0];
    pin_raw[CH_IDX_FIVE] = ded_pin_in[1];
    pin_raw[CH_IDX_TEN] = ded_pin_in[2];
    ded_pin_out = {drv[CH_IDX_TEN].out, drv[CH_IDX_FIVE].out, drv[CH_IDX_FOUR].out};
    ded_pin_oe_n = {drv[CH_IDX_TEN].oe_n, drv[CH_IDX_FIVE].oe_n, drv[CH_IDX_FOUR].oe_n};

    // The unselected port stays released, so one channel never drives two pins.
    for (int i = 0; i < 4; i++) begin
      if (alt_pin_map_sel) begin
        pin_raw[CH_IDX_NINE - i] = pe_pin_in[i];
        pe_pin_out[i] = drv[CH_IDX_NINE - i].out;
        pe_pin_oe_n[i] = drv[CH_IDX_NINE - i].oe_n;
      end else begin
        pin_raw[CH_IDX_NINE - i] = ph_pin_in[i];
        ph_pin_out[i] = drv[CH_IDX_NINE - i].out;
        ph_pin_oe_n[i] = drv[CH_IDX_NINE - i].oe_n;
      end
    end

    // Channel ten has no open-drain bit, so its driver is always push-pull.
    for (int k = 0; k < OD_CHANNELS; k++) begin
      od_en[k] = st_q.od[OD_LSB + k];
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar gk = 0; gk < NUM_CH; gk++) begin : g_ch
    // Bits two and one of an odd timer number index the four capture time bases.
    assign chan_timer[gk] = cc_timer_val[st_q.tsel[gk].cc[2:1]];

    cct_cap_chan #(
      .TW_P(TW)
    ) u_chan (
      .mclk(mclk),
      .arst_n(arst_n),
      .mode(st_q.ctrl[gk][MODE_W-1:0]),
      .pin_raw(pin_raw[gk]),
      .pin_is_out(!pin_direction[gk]),
      .port_latch(port_latch[gk]),
      .timer_val(chan_timer[gk]),
      .wr_lo(wr_lo[gk]),
      .wr_hi(wr_hi[gk]),
      .wdata(bus_req.wdata),
      .cap_value(cap_value[gk]),
      .cap_pulse(cap_pulse[gk])
    );

    cct_pin_drv u_drv (
      .mclk(mclk),
      .arst_n(arst_n),
      .mode(st_q.ctrl[gk][MODE_W-1:0]),
      .od_en(od_en[gk]),
      .dir_in(pin_direction[gk]),
      .val(chan_out_val[gk]),
      .drv(drv[gk])
    );
  end

  assign bus_rdata = st_q.rdata;
  assign chan_timer_sel = st_q.tsel;
  assign capture_event = cap_pulse;
  assign capture_flag = st_q.flag[FLAG_LSB +: NUM_CH];
  assign capture_irq_enable = st_q.ien[FLAG_LSB +: NUM_CH];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  flag_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (|cap_pulse) |=> ((capture_flag & $past(cap_pulse)) == $past(cap_pulse)))
    else $error("capture did not set its flag");

  flag_keep_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !$past(bus_req.wr && (bus_req.addr == ADDR_FLAG)) |-> ((st_q.flag & $past(st_q.flag)) == $past(st_q.flag)))
    else $error("flag cleared without a software write");

  ch4_decode_a: assert property (@(posedge mclk) disable iff (!arst_n)
    ($past(st_q.tsa[SEL4_LSB +: 2]) == 2'b01) |->
      (chan_timer_sel[CH_IDX_FOUR] == cct_tsel_type'{cc: TMR_THREE, pwm: TMR_FOUR}))
    else $error("channel four timer decode wrong");

  ch7_decode_a: assert property (@(posedge mclk) disable iff (!arst_n)
    ($past(st_q.tsa[SEL7_LSB +: 2]) == 2'b11) |->
      (chan_timer_sel[CH_IDX_SEVEN] == cct_tsel_type'{cc: TMR_FIVE, pwm: TMR_EIGHT}))
    else $error("channel seven timer decode wrong");

  ch8_small_a: assert property (@(posedge mclk) disable iff (!arst_n)
    SMALL_MEM |-> (chan_timer_sel[CH_IDX_EIGHT].cc == TMR_ONE))
    else $error("small variant channel eight left timer one");

  tsel_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (bus_req.rd && (bus_req.addr == ADDR_TSEL_A)) |=> (bus_rdata == $past(st_q.tsa)))
    else $error("select register read back wrong");

  alt_map_a: assert property (@(posedge mclk) disable iff (!arst_n)
    alt_pin_map_sel |-> ((ph_pin_oe_n == '1) && (pe_pin_oe_n[0] == drv[CH_IDX_NINE].oe_n)))
    else $error("pin map follows wrong port");

  rdata_idle_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !bus_req.rd |=> (bus_rdata == RESET_VAL))
    else $error("read data left standing");

  pe_release_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !alt_pin_map_sel |-> ((pe_pin_oe_n == '1) && (pe_pin_out == '0)))
    else $error("unselected port still driven");
endmodule : cct_top
